// ---- include/aipc_defines.svh ----
// offsets, field positions, reset values and timing counts of the interrupt pin block
`ifndef AIPC_DEFINES_SVH
`define AIPC_DEFINES_SVH
`define AIPC_A_RELEASE 7'h17
`define AIPC_A_MAIN    7'h18
`define AIPC_A_ODR     7'h1B
`define AIPC_A_PIN1    7'h1C
`define AIPC_A_MDIR    7'h1D
`define AIPC_A_TDIR    7'h1E
`define AIPC_A_ROUTE1  7'h1F
`define AIPC_A_PIN2    7'h20
`define AIPC_A_ROUTE2  7'h21
`define AIPC_RST_MAIN  8'h00
`define AIPC_RST_ODR   8'h00
`define AIPC_RST_PIN   8'h10
`define AIPC_RST_DIR   8'h3F
`define AIPC_RST_ROUTE 8'h00
`define AIPC_MSK_ODR   8'hCF
`define AIPC_MSK_PIN1  8'hFB
`define AIPC_MSK_MDIR  8'h7F
`define AIPC_MSK_TDIR  8'h3F
`define AIPC_MSK_PIN2  8'hFE
`define AIPC_B_MODE    7
`define AIPC_B_BYPASS  7
`define AIPC_B_LOWPASS_ROLLOFF_SELECT    6
`define AIPC_B_PW_HI   7
`define AIPC_B_PW_LO   6
`define AIPC_B_EN      5
`define AIPC_B_POL     4
`define AIPC_B_RESP    3
`define AIPC_B_SECOND_AUTO_CLEAR   2
`define AIPC_B_FIRST_AUTO_CLEAR   1
`define AIPC_B_SELFTEST_POLARITY   1
`define AIPC_B_SPI3    0
`define AIPC_B_COMB    6
`define AIPC_EV_TAP    2
`define AIPC_EV_WAKE   1
`define AIPC_AUTO_MSK  8'h8F
`define AIPC_RATE_MAX  4'h8
`define AIPC_LPF_SLOW  4'h9
`define AIPC_LPF_FAST  4'h2
`define AIPC_CLK_NS    5
`define AIPC_CLK_HZ    200000000
`define AIPC_PULSE_NS  50000
`define AIPC_ODR_TOP_HZ 200
`define AIPC_PULSE_CYC ((`AIPC_PULSE_NS + `AIPC_CLK_NS - 1) / `AIPC_CLK_NS)
`define AIPC_ODR_TOP_CYC (`AIPC_CLK_HZ / `AIPC_ODR_TOP_HZ)
`endif

// ---- include/aipc_pkg.sv ----
// types shared by the interrupt pin block
package aipc_pkg;
   typedef logic [7:0] aipc_byte_t;
   typedef enum logic {PIN_IDLE, PIN_PULSE} aipc_pin_st_t;
endpackage

// ---- include/aipc_pin_if.sv ----
// bundle between the register file and one interrupt pin driver
`timescale 1ns/1ps
`default_nettype none
interface aipc_pin_if;
   logic        en;
   logic        pol;
   logic        resp;
   logic [1:0]  pw;
   logic [29:0] period;
   logic        trig;
   logic        hold;
   logic        level;
   logic        trail;
   modport ctl (output en, pol, resp, pw, period, trig, hold, input level, trail);
   modport drv (input en, pol, resp, pw, period, trig, hold, output level, trail);
endinterface
`default_nettype wire

// ---- rtl/aipc_pin_drv.sv ----
// one interrupt pin: latched or pulsed response, polarity and enable
`timescale 1ns/1ps
`default_nettype none
`include "aipc_defines.svh"
module aipc_pin_drv import aipc_pkg::*; #(
   parameter int PULSE_CYC = `AIPC_PULSE_CYC
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   aipc_pin_if.drv   pin
);
   aipc_pin_st_t st_r;
   logic [29:0]  cnt_r;
   logic [29:0]  width;
   logic [29:0]  len_r;
   logic         level_r;
   logic         trail_r;
   logic         active;

   // ==========================================================
   // pulse width; the reserved code falls back to the short pulse
   always_comb begin
      unique case (pin.pw)
         2'h1:    width = pin.period; // [RULE4]
         2'h2:    width = {pin.period[28:0], 1'b0}; // [RULE4]
         default: width = 30'(PULSE_CYC); // [RULE4]
      endcase
   end

   // ==========================================================
   // pulse sequencer; a new event during a pulse does not stretch it
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_r    <= PIN_IDLE;
         cnt_r   <= 30'h0;
         trail_r <= 1'b0;
      end else begin
         trail_r <= 1'b0;
         unique case (st_r)
            PIN_IDLE: if (pin.en && pin.resp && pin.trig) begin // [RULE7]
               cnt_r <= width - 30'h1;
               st_r  <= PIN_PULSE;
            end
            PIN_PULSE: if (cnt_r == 30'h0) begin
               st_r    <= PIN_IDLE;
               trail_r <= 1'b1; // trailing edge for auto clear [RULE8]
            end else begin
               cnt_r <= cnt_r - 30'h1;
            end
         endcase
      end
   end

   // latched mode follows the routed pending sources
   assign active = pin.en && (pin.resp ? (st_r == PIN_PULSE) : pin.hold); // [RULE5] [RULE7] [RULE18]

   // ==========================================================
   // registered pin level at the selected polarity
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         level_r <= 1'b0; // inactive level of the reset polarity, so no false indication
      end else begin
         level_r <= active ? pin.pol : !pin.pol; // [RULE6] [RULE18]
      end
   end

   assign pin.level = level_r;
   assign pin.trail = trail_r;

   // helper: length of the current pulse
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         len_r <= 30'h0;
      end else begin
         len_r <= (st_r == PIN_PULSE) ? len_r + 30'h1 : 30'h0;
      end
   end

   pulse_len_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE4]
      (st_r == PIN_PULSE) && (cnt_r == 30'h0) |-> len_r == width - 30'h1)
      else $error("pulse length differs from selected width");
endmodule // aipc_pin_drv
`default_nettype wire

// ---- rtl/aipc_spi_link.sv ----
// serial register port: link clock side and crossing into the core clock
`timescale 1ns/1ps
`default_nettype none
module aipc_spi_link (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       spi_sclk,
   input  wire logic       spi_cs_n,
   input  wire logic       sdi_in,
   output logic            sdi_out,
   output logic            sdi_oe,
   output logic            sdo_out,
   output logic            sdo_oe,
   input  wire logic       three_wire,
   input  wire logic [7:0] rd_data,
   output logic [6:0]      addr,
   output logic [7:0]      wr_data,
   output logic            wr_stb,
   output logic            rd_stb
);
   logic [4:0] cnt_r;
   logic [6:0] sh_r;
   logic       rd_r;
   logic       wr_lvl_r;
   logic       rd_lvl_r;
   logic [1:0] tw_r;
   logic       out_r;
   logic [2:0] wr_s_r;
   logic [2:0] rd_s_r;
   logic       drive;

   // ==========================================================
   // link side; chip select ends every frame, since the clock stops
   always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         cnt_r    <= 5'h0;
         rd_r     <= 1'b0;
         wr_lvl_r <= 1'b0;
         rd_lvl_r <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == 5'h1F) ? cnt_r : cnt_r + 5'h1;
         if (cnt_r == 5'h0) rd_r <= sdi_in;
         if (cnt_r == 5'h7) rd_lvl_r <= rd_r;
         if (cnt_r == 5'hF) wr_lvl_r <= !rd_r;
      end
   end

   // address and data stay put after the frame so the core can take them late
   always_ff @(posedge spi_sclk) begin
      sh_r <= {sh_r[5:0], sdi_in};
      if (cnt_r == 5'h7) addr <= {sh_r[5:0], sdi_in};
      if (cnt_r == 5'hF) wr_data <= {sh_r[6:0], sdi_in};
   end

   // wiring mode brought into the link clock
   always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) tw_r <= 2'h0;
      else tw_r <= {tw_r[0], three_wire};
   end

   // read data is held by the core for many link periods before use
   always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
      if (spi_cs_n) out_r <= 1'b0;
      else if (cnt_r >= 5'h10 && cnt_r < 5'h18) out_r <= rd_data[3'(5'h17 - cnt_r)];
   end

   assign drive   = !spi_cs_n && rd_r && (cnt_r >= 5'h10);
   assign sdo_out = out_r;
   assign sdi_out = out_r;
   assign sdo_oe  = drive && !tw_r[1]; // [RULE10]
   assign sdi_oe  = drive && tw_r[1]; // [RULE10]

   // ==========================================================
   // core side: request levels pass two flops, then an edge detect
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wr_s_r <= 3'h0;
         rd_s_r <= 3'h0;
      end else begin
         wr_s_r <= {wr_s_r[1:0], wr_lvl_r};
         rd_s_r <= {rd_s_r[1:0], rd_lvl_r};
      end
   end

   assign wr_stb = wr_s_r[1] && !wr_s_r[2];
   assign rd_stb = rd_s_r[1] && !rd_s_r[2];
endmodule // aipc_spi_link
`default_nettype wire

// ---- rtl/aipc_top.sv ----
// interrupt pin configuration, source latching and pin output for the accelerometer
// Behaviour
// (RULE1) host enters standby before changing configuration
// (RULE2) rate code doubles from 0.781 to 200 Hz
// (RULE3) roll-off bit picks corner ODR/9 or ODR/2
// (RULE4) width: 50 us, one or two periods
// (RULE5) per-pin enable bit, disabled pin stays inactive
// (RULE6) per-pin polarity: 0 low, 1 high
// (RULE7) latched until release read, or single pulse
// (RULE8) auto clear latched sources at pulse end; the code clears only sources 7 and 3 to 0, sources 6 to 4 stay latched
// (RULE9) self-test polarity bit: positive or negative
// (RULE10) wiring bit: four-wire or three-wire serial
// (RULE11) motion combine: any direction or every axis
// (RULE12) six motion direction enables, reset all on
// (RULE13) six tap direction enables, reset all on
// (RULE14) eight routing bits send sources to first pin
// (RULE15) independent eight routing bits for second pin
// (RULE16) release read clears latches, returns dummy value
// (RULE17) operating-mode bit: standby or active sensing
// (RULE18) pin is enabled OR of routed pending sources
`timescale 1ns/1ps
`default_nettype none
`include "aipc_defines.svh"
module aipc_top import aipc_pkg::*; #(
   parameter int PULSE_CYC   = `AIPC_PULSE_CYC,
   parameter int ODR_TOP_CYC = `AIPC_ODR_TOP_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       spi_sclk,
   input  wire logic       spi_cs_n,
   input  wire logic       sdi_in,
   output logic            sdi_out,
   output logic            sdi_oe,
   output logic            sdo_out,
   output logic            sdo_oe,
   input  wire logic [7:0] event_in,
   input  wire logic [5:0] motion_dir_hit,
   input  wire logic [5:0] tap_dir_hit,
   output logic            first_irq_pin,
   output logic            second_irq_pin,
   output logic            operating_mode_bit,
   output logic [3:0]      sample_rate_code,
   output logic [29:0]     odr_period_cyc,
   output logic [3:0]      lowpass_corner_div,
   output logic            filter_bypass,
   output logic            selftest_polarity,
   output logic            three_wire_select,
   output logic            motion_active,
   output logic [7:0]      irq_pending,
   output logic            irq_any
);
   aipc_byte_t  main_r;
   aipc_byte_t  odr_r;
   aipc_byte_t  pin1_r;
   aipc_byte_t  mdir_r;
   aipc_byte_t  tdir_r;
   aipc_byte_t  route1_r;
   aipc_byte_t  pin2_r;
   aipc_byte_t  route2_r;
   aipc_byte_t  rd_data_r;
   aipc_byte_t  rd_mux;
   aipc_byte_t  pend_r;
   aipc_byte_t  pend_nxt;
   aipc_byte_t  set_src;
   aipc_byte_t  clr_src;
   logic [6:0]  addr;
   logic [7:0]  wr_data;
   logic        wr_stb;
   logic        rd_stb;
   logic        release_rd;
   logic [3:0]  rate_clamp;
   logic [3:0]  rate_shift;
   logic [29:0] period_r;
   logic [3:0]  lpf_r;
   logic        motion_hit;
   logic        motion_r;
   logic        tap_hit;
   logic        any_r;
   logic [5:0]  m_en;
   logic        auto1;
   logic        auto2;

   aipc_pin_if p1 ();
   aipc_pin_if p2 ();

   // ==========================================================
   // serial register port
   aipc_spi_link u_link (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .spi_sclk   (spi_sclk),
      .spi_cs_n   (spi_cs_n),
      .sdi_in     (sdi_in),
      .sdi_out    (sdi_out),
      .sdi_oe     (sdi_oe),
      .sdo_out    (sdo_out),
      .sdo_oe     (sdo_oe),
      .three_wire (pin1_r[`AIPC_B_SPI3]),
      .rd_data    (rd_data_r),
      .addr       (addr),
      .wr_data    (wr_data),
      .wr_stb     (wr_stb),
      .rd_stb     (rd_stb)
   );

   // ==========================================================
   // register writes; reserved bits are kept at zero
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         main_r   <= `AIPC_RST_MAIN;
         odr_r    <= `AIPC_RST_ODR;
         pin1_r   <= `AIPC_RST_PIN;
         mdir_r   <= `AIPC_RST_DIR; // [RULE12]
         tdir_r   <= `AIPC_RST_DIR; // [RULE13]
         route1_r <= `AIPC_RST_ROUTE;
         pin2_r   <= `AIPC_RST_PIN;
         route2_r <= `AIPC_RST_ROUTE;
      end else if (wr_stb) begin
         // writes are not gated by the mode bit; the host keeps to standby
         unique case (addr)
            `AIPC_A_MAIN:   main_r   <= wr_data; // [RULE17]
            `AIPC_A_ODR:    odr_r    <= wr_data & `AIPC_MSK_ODR;
            `AIPC_A_PIN1:   pin1_r   <= wr_data & `AIPC_MSK_PIN1;
            `AIPC_A_MDIR:   mdir_r   <= wr_data & `AIPC_MSK_MDIR; // [RULE12]
            `AIPC_A_TDIR:   tdir_r   <= wr_data & `AIPC_MSK_TDIR; // [RULE13]
            `AIPC_A_ROUTE1: route1_r <= wr_data; // [RULE14]
            `AIPC_A_PIN2:   pin2_r   <= wr_data & `AIPC_MSK_PIN2;
            `AIPC_A_ROUTE2: route2_r <= wr_data; // [RULE15]
            default: ;
         endcase
      end
   end

   // ==========================================================
   // read mux; the release register and unmapped offsets read zero
   always_comb begin
      unique case (addr)
         `AIPC_A_MAIN:   rd_mux = main_r;
         `AIPC_A_ODR:    rd_mux = odr_r;
         `AIPC_A_PIN1:   rd_mux = pin1_r;
         `AIPC_A_MDIR:   rd_mux = mdir_r;
         `AIPC_A_TDIR:   rd_mux = tdir_r;
         `AIPC_A_ROUTE1: rd_mux = route1_r;
         `AIPC_A_PIN2:   rd_mux = pin2_r;
         `AIPC_A_ROUTE2: rd_mux = route2_r;
         default:        rd_mux = 8'h00; // [RULE16]
      endcase
   end

   // read data is held until the next read request, long enough for the link
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rd_data_r <= 8'h00;
      end else if (rd_stb) begin
         rd_data_r <= rd_mux;
      end
   end

   assign release_rd = rd_stb && (addr == `AIPC_A_RELEASE); // [RULE16]

   // ==========================================================
   // rate period and filter corner
   assign rate_clamp = (odr_r[3:0] > `AIPC_RATE_MAX) ? `AIPC_RATE_MAX : odr_r[3:0];
   assign rate_shift = `AIPC_RATE_MAX - rate_clamp;

   // each code step halves the period; codes above the top clamp to it
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         period_r <= 30'h0;
         lpf_r    <= `AIPC_LPF_SLOW;
      end else begin
         period_r <= 30'(ODR_TOP_CYC) << rate_shift; // [RULE2]
         lpf_r    <= odr_r[`AIPC_B_LOWPASS_ROLLOFF_SELECT] ? `AIPC_LPF_FAST : `AIPC_LPF_SLOW; // [RULE3]
      end
   end

   // ==========================================================
   // motion and tap direction qualification
   assign m_en = motion_dir_hit & mdir_r[5:0]; // [RULE12]
   // and mode needs every axis to fire in one of its enabled directions
   assign motion_hit = mdir_r[`AIPC_B_COMB] ? // [RULE11]
                       ((|m_en[5:4]) && (|m_en[3:2]) && (|m_en[1:0])) : (|m_en);
   assign tap_hit = |(tap_dir_hit & tdir_r[5:0]); // [RULE13]

   assign set_src = {event_in[7:3],
                     event_in[`AIPC_EV_TAP] && tap_hit,
                     event_in[`AIPC_EV_WAKE] && motion_hit,
                     event_in[0]};

   // ==========================================================
   // latched sources; a new event wins over any clear in the same cycle
   assign auto1 = p1.trail && pin2_r[`AIPC_B_FIRST_AUTO_CLEAR] && pin1_r[`AIPC_B_RESP]; // [RULE8]
   assign auto2 = p2.trail && pin2_r[`AIPC_B_SECOND_AUTO_CLEAR] && pin2_r[`AIPC_B_RESP]; // [RULE8]
   assign clr_src = (release_rd ? 8'hFF : 8'h00) // [RULE16]
                  | ((auto1 || auto2) ? `AIPC_AUTO_MSK : 8'h00); // [RULE8]
   assign pend_nxt = (pend_r & ~clr_src) | set_src;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pend_r   <= 8'h00;
         motion_r <= 1'b0;
         any_r    <= 1'b0;
      end else begin
         pend_r   <= pend_nxt;
         motion_r <= motion_hit;
         any_r    <= |(pend_r & (route1_r | route2_r));
      end
   end

   // ==========================================================
   // pin configuration bundles
   assign p1.en     = pin1_r[`AIPC_B_EN]; // [RULE5]
   assign p1.pol    = pin1_r[`AIPC_B_POL]; // [RULE6]
   assign p1.resp   = pin1_r[`AIPC_B_RESP]; // [RULE7]
   assign p1.pw     = pin1_r[`AIPC_B_PW_HI:`AIPC_B_PW_LO]; // [RULE4]
   assign p1.period = period_r;
   assign p1.trig   = |(set_src & route1_r); // [RULE14]
   assign p1.hold   = |(pend_r & route1_r); // [RULE14] [RULE18]
   assign p2.en     = pin2_r[`AIPC_B_EN]; // [RULE5]
   assign p2.pol    = pin2_r[`AIPC_B_POL]; // [RULE6]
   assign p2.resp   = pin2_r[`AIPC_B_RESP]; // [RULE7]
   assign p2.pw     = pin2_r[`AIPC_B_PW_HI:`AIPC_B_PW_LO]; // [RULE4]
   assign p2.period = period_r;
   assign p2.trig   = |(set_src & route2_r); // [RULE15]
   assign p2.hold   = |(pend_r & route2_r); // [RULE15] [RULE18]

   aipc_pin_drv #(.PULSE_CYC(PULSE_CYC)) u_pin1 (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .pin     (p1.drv)
   );

   aipc_pin_drv #(.PULSE_CYC(PULSE_CYC)) u_pin2 (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .pin     (p2.drv)
   );

   // ==========================================================
   // outputs
   assign first_irq_pin      = p1.level;
   assign second_irq_pin     = p2.level;
   assign operating_mode_bit = main_r[`AIPC_B_MODE]; // [RULE17]
   assign sample_rate_code   = odr_r[3:0]; // [RULE2]
   assign odr_period_cyc     = period_r;
   assign lowpass_corner_div = lpf_r;
   assign filter_bypass      = odr_r[`AIPC_B_BYPASS];
   assign selftest_polarity  = pin1_r[`AIPC_B_SELFTEST_POLARITY]; // [RULE9]
   assign three_wire_select  = pin1_r[`AIPC_B_SPI3]; // [RULE10]
   assign motion_active      = motion_r;
   assign irq_pending        = pend_r;
   assign irq_any            = any_r;

   // ==========================================================
   // checks
   odr_top_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE2]
      odr_r[3:0] == 4'h8 ##1 odr_r[3:0] == 4'h8 |-> period_r == 30'(ODR_TOP_CYC))
      else $error("top rate period wrong");

   odr_slow_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE2]
      odr_r[3:0] == 4'h0 ##1 odr_r[3:0] == 4'h0 |-> period_r == 30'(ODR_TOP_CYC) * 30'h100)
      else $error("slowest rate period wrong");

   lpf_corner_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE3]
      odr_r[`AIPC_B_LOWPASS_ROLLOFF_SELECT] |=> lpf_r == `AIPC_LPF_FAST)
      else $error("filter corner divider wrong");

   release_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE16]
      release_rd && set_src == 8'h00 |=> pend_r == 8'h00 ##1
      ($past(p1.resp) || !$stable(p1.pol) || first_irq_pin == !p1.pol))
      else $error("release read left sources latched");

   set_wins_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE16]
      release_rd && set_src[7] |=> pend_r[7])
      else $error("event lost on release");

   pin_off_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE5]
      !p1.en ##1 (!p1.en && $stable(p1.pol)) |-> first_irq_pin == !p1.pol)
      else $error("disabled pin shows an interrupt");

   pin_pol_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE6]
      (p2.en && !p2.resp && p2.hold) ##1 $stable(p2.pol) |-> second_irq_pin == p2.pol)
      else $error("latched pin not at active level");

   latch_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE7]
      p1.hold && !release_rd && !auto1 && !auto2 |=> p1.hold || route1_r != $past(route1_r))
      else $error("latched source dropped without release");

   auto_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE8]
      auto1 && (set_src & `AIPC_AUTO_MSK) == 8'h00 |=> (pend_r & `AIPC_AUTO_MSK) == 8'h00)
      else $error("auto clear missed");

   and_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE11]
      mdir_r[`AIPC_B_COMB] && motion_dir_hit[3:0] == 4'h0 |=> !motion_r)
      else $error("and mode fired with two axes idle");

   tap_mask_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE13]
      !pend_r[2] && (tap_dir_hit & tdir_r[5:0]) == 6'h00 |=> !pend_r[2])
      else $error("masked tap latched");
endmodule // aipc_top
`default_nettype wire

// ---- verification/aipc_host_model.sv ----
// serial host model that reaches the registers of the interrupt pin block
`timescale 1ns/1ps
`default_nettype none
module aipc_host_model (
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      sdi_in,
   input  wire logic sdi_out,
   input  wire logic sdi_oe,
   input  wire logic sdo_out,
   input  wire logic sdo_oe
);
   // ==========
   // frame driver
   logic sdo_line;
   // read data comes on whichever pin is driven; a released line shows the inverse of sdi
   assign sdo_line = sdo_oe ? sdo_out : sdi_oe ? sdi_out : ~sdi_in;
   // link clock stands still low outside frames
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      sdi_in   = 1'b0;
   end
   // one byte per frame: r/w bit, address msb first, then data or turnaround
   task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                         output logic [7:0] rdat);
      logic [15:0] sh;
      int          n;
      sh = {rd, a, wd};
      n = rd ? 24 : 16;
      spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi_in = (i < 16) ? sh[15 - i] : ~sdi_in; // idle bits keep toggling
         #32 spi_sclk = 1'b1;
         if (i >= 16) rdat = {rdat[6:0], sdo_line};
         #32 spi_sclk = 1'b0;
      end
      spi_cs_n = 1'b1;
      #40;
   endtask
endmodule // aipc_host_model
`default_nettype wire

// ---- verification/accel_interrupt_pin_config_tb.sv ----
// self-checking bench for the interrupt pin block
`timescale 1ns/1ps
`default_nettype none
`include "aipc_defines.svh"
module accel_interrupt_pin_config_tb;
   localparam int PC = 20;
   localparam int OC = 8;
   logic ref_clk = 1'b0, resetn = 1'b0;
   logic spi_sclk, spi_cs_n, sdi_in, sdo_out, sdo_oe, first_irq_pin, second_irq_pin;
   logic sdi_out, sdi_oe, irq_any;
   logic operating_mode_bit, filter_bypass, selftest_polarity, three_wire_select, motion_active;
   logic [7:0] event_in = 8'h00, irq_pending, rd;
   logic [5:0] motion_dir_hit = 6'h00, tap_dir_hit = 6'h00;
   logic [3:0] sample_rate_code, lowpass_corner_div;
   logic [29:0] odr_period_cyc;
   logic [6:0] adr[7] = '{7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F, 7'h20, 7'h21};
   logic [7:0] rst[7] = '{8'h00, 8'h10, 8'h3F, 8'h3F, 8'h00, 8'h10, 8'h00};
   logic [7:0] msk[7] = '{8'hCF, 8'hFA, 8'h7F, 8'h3F, 8'hFF, 8'hFE, 8'hFF};
   int wid[4] = '{PC, OC, 2 * OC, PC};
   int bad_count = 0;
   int checks = 0;
   // ==========
   // clock, design and host
   always #2.5 ref_clk = ~ref_clk;
   aipc_top #(.PULSE_CYC(PC), .ODR_TOP_CYC(OC)) aipc_top_inst (.ref_clk, .resetn, .spi_sclk,
      .spi_cs_n, .sdi_in, .sdi_out, .sdi_oe, .sdo_out, .sdo_oe, .event_in, .motion_dir_hit,
      .tap_dir_hit, .first_irq_pin, .second_irq_pin, .operating_mode_bit, .sample_rate_code,
      .odr_period_cyc, .lowpass_corner_div, .filter_bypass, .selftest_polarity,
      .three_wire_select, .motion_active, .irq_pending, .irq_any);
   aipc_host_model aipc_host_model_inst (.spi_sclk, .spi_cs_n, .sdi_in, .sdi_out, .sdi_oe,
      .sdo_out, .sdo_oe);
   // ==========
   // helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // the host returns long after the write lands, then realigns to the drive edge
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      aipc_host_model_inst.access(1'b0, a, d, rd);
      @(negedge ref_clk);
   endtask
   task automatic rdreg(input logic [6:0] a);
      aipc_host_model_inst.access(1'b1, a, 8'h00, rd);
      @(negedge ref_clk);
   endtask
   // one-cycle event, then two edges for latch and pin
   task automatic fire(input int b);
      event_in = 8'h01 << b;
      @(negedge ref_clk);
      event_in = 8'h00;
      repeat (2) @(negedge ref_clk);
   endtask
   function automatic logic mot(logic [6:0] c, logic [5:0] h);
      logic [5:0] q;
      q = c[5:0] & h;
      return c[6] ? (|q[5:4] && |q[3:2] && |q[1:0]) : |q;
   endfunction
   // ==========
   // main sequence
   initial begin
      logic [7:0] r, d;
      int         w;
      r = 8'($urandom(32'h1A28FA5D));
      repeat (10) @(negedge ref_clk);
      resetn = 1'b1;
      @(negedge ref_clk);
      foreach (adr[i]) begin
         rdreg(adr[i]);
         check("reset value", rd, rst[i]);
      end
      wr(`AIPC_A_MAIN, 8'h80);
      check("mode", operating_mode_bit, 1);
      wr(`AIPC_A_MAIN, 8'h00); // standby before configuration
      check("mode", operating_mode_bit, 0);
      for (int c = 0; c < 10; c++) begin
         d = {2'($urandom), 2'b00, 4'(c)};
         wr(`AIPC_A_ODR, d);
         check("rate", sample_rate_code, d[3:0]);
         check("period", odr_period_cyc, OC << (8 - (c > 8 ? 8 : c)));
         check("corner", lowpass_corner_div, d[6] ? 4'h2 : 4'h9);
         check("bypass", filter_bypass, d[7]);
      end
      for (int i = 1; i < 7; i++) begin
         d = 8'($urandom) & msk[i];
         wr(adr[i], d);
         rdreg(adr[i]);
         check("readback", rd, d);
         if (i == 1) check("selftest", selftest_polarity, d[1]);
      end
      rdreg(7'h30);
      check("unmapped", rd, 0);
      wr(`AIPC_A_PIN1, 8'h01);
      check("wiring", three_wire_select, 1);
      rdreg(`AIPC_A_PIN1);
      check("three-wire read", rd, 8'h01);
      wr(`AIPC_A_PIN1, 8'h00);
      check("wiring", three_wire_select, 0);
      for (int k = 0; k < 8; k++) begin
         d = 8'($urandom) & 8'h7F;
         wr(`AIPC_A_MDIR, d);
         repeat (4) begin
            motion_dir_hit = 6'($urandom);
            @(negedge ref_clk);
            check("motion", motion_active, mot(d[6:0], motion_dir_hit));
         end
      end
      wr(`AIPC_A_MDIR, 8'h3F);
      motion_dir_hit = 6'h3F;
      for (int k = 0; k < 4; k++) begin
         d = 8'($urandom) & 8'h3F;
         tap_dir_hit = 6'($urandom);
         wr(`AIPC_A_TDIR, d);
         fire(`AIPC_EV_TAP);
         check("tap", irq_pending[2], |(d[5:0] & tap_dir_hit));
         rdreg(`AIPC_A_RELEASE);
      end
      wr(`AIPC_A_TDIR, 8'h3F);
      tap_dir_hit = 6'h3F;
      // first pin active high, second active low, both latched
      wr(`AIPC_A_PIN1, 8'h30);
      wr(`AIPC_A_PIN2, 8'h20);
      wr(`AIPC_A_ROUTE1, r);
      wr(`AIPC_A_ROUTE2, ~r);
      for (int b = 0; b < 8; b++) begin
         fire(b);
         check("pending", irq_pending, 8'h01 << b);
         check("pin1", first_irq_pin, r[b]);
         check("pin2", second_irq_pin, r[b]);
         check("any", irq_any, 1);
         rdreg(`AIPC_A_RELEASE);
         check("release", {irq_any, first_irq_pin, second_irq_pin, irq_pending}, 11'h100);
      end
      wr(`AIPC_A_PIN1, 8'h10);
      wr(`AIPC_A_ROUTE1, 8'h01);
      fire(0);
      check("disabled", first_irq_pin, 0);
      rdreg(`AIPC_A_RELEASE);
      // pulse widths with auto clear from the first pin
      wr(`AIPC_A_ODR, 8'h08);
      wr(`AIPC_A_PIN2, 8'h02);
      for (int p = 0; p < 4; p++) begin
         wr(`AIPC_A_PIN1, {2'(p), 6'h38});
         fire(0);
         w = 2; // the pulse already stands at the last two edges inside fire
         repeat (60) begin
            @(negedge ref_clk);
            w += first_irq_pin;
         end
         check("width", w, wid[p]);
         check("auto clear", irq_pending, 0);
      end
      // second pin pulsed with its own auto clear; first pin no longer clears
      wr(`AIPC_A_ROUTE2, 8'h01);
      wr(`AIPC_A_PIN2, 8'h3C);
      fire(0);
      repeat (60) @(negedge ref_clk);
      check("auto clear 2", irq_pending, 0);
      wr(`AIPC_A_PIN2, 8'h00);
      fire(0);
      repeat (60) @(negedge ref_clk);
      check("no auto clear", irq_pending, 8'h01);
      finish_test();
   end
   // watchdog well beyond the expected run length
   initial begin
      #400000;
      bad_count++;
      finish_test();
   end
endmodule // accel_interrupt_pin_config_tb
`default_nettype wire
